// ### verilog/sam_alarm_manager.sv
// Top of the servo alarm manager: latch, clear, power enable, link errors
`timescale 1ns/100ps
`include "sam_defines.svh"
module sam_alarm_manager #(
   parameter int PW = 24,
   parameter logic [15:0] MAX_SPEED = 16'd5000,
   parameter logic [11:0] DC_MIN = 12'd200,
   parameter logic [11:0] DC_MAX = 12'd400,
   parameter int DISP_STEP_CYC = `SAM_DISP_STEP_MS * `SAM_CLK_KHZ,
   parameter int PU_INIT_CYC = `SAM_PU_INIT_MS * `SAM_CLK_KHZ
) (
   // Clock and reset (reset stands for a power cycle)
   input wire logic i_clk,
   input wire logic i_srst,
   // Host pins
   input wire logic i_alarm_reset,
   input wire logic i_run,
   // Parameter unit
   input wire logic i_key_reset,
   input wire logic i_pu_rx_ok,
   input wire logic i_pu_timeout,
   // Monitors
   input wire logic [3:0] i_motor_type,
   input wire logic [3:0] i_cfg_motor_type,
   input wire logic [9:0] i_torque_pct,
   input wire logic [7:0] i_regen_pct,
   input wire logic [PW-1:0] i_resid_pulses,
   input wire logic [PW-1:0] i_overflow_level_setting,
   input wire logic i_cmd_dir,
   input wire logic i_meas_dir,
   input wire logic i_moving,
   input wire logic [15:0] i_speed,
   input wire logic [2:0] i_enc_open,
   input wire logic [2:0] i_enc_short,
   input wire logic [11:0] i_dc_volt,
   input wire logic i_overcurrent,
   input wire logic i_sys_error,
   input wire logic i_phase_error,
   input wire logic i_regen_error,
   input wire logic i_db_overload,
   input wire logic i_inrush_overload,
   input wire logic i_overheat,
   // Status
   output logic o_fault_output,
   output logic o_power_enable,
   output logic [7:0] o_alarm_code,
   output logic o_warning,
   output logic [7:0] o_seg,
   output logic o_pu_err_init,
   output logic o_pu_err_timeout
);
   typedef struct packed {
      logic [2:0] rst_sync;
      logic [2:0] run_sync;
      logic rst_lvl;
      logic run_lvl;
      sam_pkg::sam_state_e st;
      logic [7:0] code;
      logic fault;
      logic pwr_en;
      logic warn;
      logic [31:0] pu_cnt;
      logic pu_seen;
      logic pu_init_err;
      logic pu_to_err;
   } sam_mgr_s;

   sam_mgr_s s;
   sam_mgr_s next_s;
   logic det_alarm;
   logic [7:0] det_code;
   logic det_warn;
   logic [7:0] det_wcode;
   logic clear_req;
   logic disp_show;
   logic [7:0] disp_code;

   function automatic logic sam_is_hard(input logic [7:0] c);
      return c == `SAM_C_PARAM || c == `SAM_C_OVERCUR || c == `SAM_C_SYSTEM ||
             c == `SAM_C_PHASE || c == `SAM_C_ENCODER;
   endfunction

   // ****************************************
   // Detection
   // ****************************************
   sam_detect #(
      .PW(PW),
      .MAX_SPEED(MAX_SPEED),
      .DC_MIN(DC_MIN),
      .DC_MAX(DC_MAX)
   ) u_detect (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_motor_type(i_motor_type),
      .i_cfg_motor_type(i_cfg_motor_type),
      .i_torque_pct(i_torque_pct),
      .i_regen_pct(i_regen_pct),
      .i_resid_pulses(i_resid_pulses),
      .i_overflow_level_setting(i_overflow_level_setting),
      .i_cmd_dir(i_cmd_dir),
      .i_meas_dir(i_meas_dir),
      .i_moving(i_moving),
      .i_speed(i_speed),
      .i_enc_open(i_enc_open),
      .i_enc_short(i_enc_short),
      .i_dc_volt(i_dc_volt),
      .i_overcurrent(i_overcurrent),
      .i_sys_error(i_sys_error),
      .i_phase_error(i_phase_error),
      .i_regen_error(i_regen_error),
      .i_db_overload(i_db_overload),
      .i_inrush_overload(i_inrush_overload),
      .i_overheat(i_overheat),
      .o_alarm(det_alarm),
      .o_alarm_code(det_code),
      .o_warn(det_warn),
      .o_warn_code(det_wcode)
   );

   // ****************************************
   // Alarm state
   // ****************************************
   // Level reset, not edge: a held reset keeps clearing once the cause is gone
   assign clear_req = s.rst_lvl | i_key_reset;

   always_comb begin
      next_s = s;
      next_s.rst_sync = {s.rst_sync[1:0], i_alarm_reset};
      next_s.run_sync = {s.run_sync[1:0], i_run};
      if (s.rst_sync[1] == s.rst_sync[2]) begin
         next_s.rst_lvl = s.rst_sync[1];
      end
      if (s.run_sync[1] == s.run_sync[2]) begin
         next_s.run_lvl = s.run_sync[1];
      end
      next_s.warn = det_warn;
      unique case (s.st)
         sam_pkg::SAM_ST_NORMAL: begin
            if (det_alarm) begin
               next_s.code = det_code;
               next_s.fault = 1'b1;
               next_s.pwr_en = 1'b0;
               next_s.st = sam_is_hard(det_code) ? sam_pkg::SAM_ST_HARD
                                                 : sam_pkg::SAM_ST_ALARM;
            end else begin
               // Warnings leave the stage running
               next_s.pwr_en = s.run_lvl;
            end
         end
         sam_pkg::SAM_ST_ALARM: begin
            // A fresh detection in the clear cycle wins; code stays held
            if (clear_req && !det_alarm) begin
               next_s.st = sam_pkg::SAM_ST_NORMAL;
               next_s.code = `SAM_RST_CODE;
               next_s.fault = 1'b0;
               // No guard here: the host must drop run before clearing
               next_s.pwr_en = s.run_lvl;
            end
         end
         sam_pkg::SAM_ST_HARD: begin
            // Only the power-cycle reset leaves this state
            next_s.st = sam_pkg::SAM_ST_HARD;
         end
         default: begin
            next_s.st = sam_pkg::SAM_ST_HARD;
            next_s.fault = 1'b1;
            next_s.pwr_en = 1'b0;
         end
      endcase
      // Parameter unit link supervision
      if (i_pu_rx_ok) begin
         next_s.pu_seen = 1'b1;
         next_s.pu_init_err = 1'b0;
      end else if (!s.pu_seen && !s.pu_init_err) begin
         if (s.pu_cnt == 32'(PU_INIT_CYC - 1)) begin
            next_s.pu_init_err = 1'b1;
         end else begin
            next_s.pu_cnt = s.pu_cnt + 32'h1;
         end
      end
      if (i_pu_timeout) begin
         next_s.pu_to_err = 1'b1;
      end else if (i_pu_rx_ok) begin
         next_s.pu_to_err = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ****************************************
   // Display
   // ****************************************
   // Link errors never reach this display, only the parameter unit flags
   assign disp_show = s.fault | s.warn;
   assign disp_code = s.fault ? s.code : det_wcode;

   sam_display #(
      .STEP_CYC(DISP_STEP_CYC)
   ) u_display (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_show(disp_show),
      .i_code(disp_code),
      .o_seg(o_seg)
   );

   assign o_fault_output = s.fault;
   assign o_power_enable = s.pwr_en;
   assign o_alarm_code = s.code;
   assign o_warning = s.warn;
   assign o_pu_err_init = s.pu_init_err;
   assign o_pu_err_timeout = s.pu_to_err;

   // ****************************************
   // Assertions
   // ****************************************
   property p_alarm_outputs;
      @(posedge i_clk) disable iff (i_srst)
      s.st != sam_pkg::SAM_ST_NORMAL |-> s.fault && !s.pwr_en;
   endproperty
   a_alarm_outputs: assert property (p_alarm_outputs)
      else $error("alarm state without fault or with power on");

   property p_latch;
      @(posedge i_clk) disable iff (i_srst)
      s.st == sam_pkg::SAM_ST_NORMAL && det_alarm |=> s.fault && s.code == $past(det_code);
   endproperty
   a_latch: assert property (p_latch)
      else $error("detected alarm not latched");

   property p_warn_run;
      @(posedge i_clk) disable iff (i_srst)
      s.st == sam_pkg::SAM_ST_NORMAL && !det_alarm && s.run_lvl |=> s.pwr_en && !s.fault;
   endproperty
   a_warn_run: assert property (p_warn_run)
      else $error("power stage off without alarm");

   property p_clear;
      @(posedge i_clk) disable iff (i_srst)
      s.st == sam_pkg::SAM_ST_ALARM && clear_req && !det_alarm
      |=> s.st == sam_pkg::SAM_ST_NORMAL && !s.fault;
   endproperty
   a_clear: assert property (p_clear)
      else $error("soft alarm not cleared");

   property p_hard_class;
      @(posedge i_clk) disable iff (i_srst)
      s.st == sam_pkg::SAM_ST_NORMAL && det_alarm && sam_is_hard(det_code)
      |=> s.st == sam_pkg::SAM_ST_HARD ##1 s.st == sam_pkg::SAM_ST_HARD;
   endproperty
   a_hard_class: assert property (p_hard_class)
      else $error("power-cycle alarm left or misclassified");

   property p_resume;
      @(posedge i_clk) disable iff (i_srst)
      s.st == sam_pkg::SAM_ST_ALARM && clear_req && !det_alarm && s.run_lvl |=> s.pwr_en;
   endproperty
   a_resume: assert property (p_resume)
      else $error("drive did not resume after clear with run on");

   property p_hold;
      @(posedge i_clk) disable iff (i_srst)
      s.st != sam_pkg::SAM_ST_NORMAL && !(s.st == sam_pkg::SAM_ST_ALARM && clear_req)
      |=> $stable(s.code);
   endproperty
   a_hold: assert property (p_hold)
      else $error("held alarm code changed");

   property p_pu_init;
      @(posedge i_clk) disable iff (i_srst)
      !s.pu_seen && !s.pu_init_err && !i_pu_rx_ok && s.pu_cnt == 32'(PU_INIT_CYC - 1)
      |=> s.pu_init_err && (!s.fault || $past(s.fault || det_alarm));
   endproperty
   a_pu_init: assert property (p_pu_init)
      else $error("power-up link error not flagged");

   c_alarm: cover property (@(posedge i_clk) disable iff (i_srst)
      s.st == sam_pkg::SAM_ST_NORMAL ##1 s.st == sam_pkg::SAM_ST_ALARM);
   c_hard: cover property (@(posedge i_clk) disable iff (i_srst)
      s.st == sam_pkg::SAM_ST_HARD);
   c_resume: cover property (@(posedge i_clk) disable iff (i_srst)
      s.st == sam_pkg::SAM_ST_ALARM ##1 s.pwr_en);
   c_warn: cover property (@(posedge i_clk) disable iff (i_srst)
      s.warn && s.pwr_en);
endmodule // sam_alarm_manager

// ### verilog/sam_defines.svh
// Constants for the servo alarm manager: codes, thresholds, timing, reset values
// Overview of operation
// - Any alarm raises the fault output, cuts the power stage, displays the code.
// - A warning displays its code while the power stage keeps running.
// - Clear a latched alarm by reset input, power cycle or parameter unit key.
// - Parameter, overcurrent, system, phase and encoder alarms clear only by power cycle.
// - If run is still on at clear, the drive restarts at once.
// - The front display steps through the code one character at a time.
// - Motor type not matching the configuration raises the parameter error.
// - Torque above 120 percent of rated raises the overload alarm.
// - Residual pulses above the overflow level setting raise deviation overflow.
// - Rotation opposite to the command raises the runaway alarm.
// - Speed above the permitted maximum raises the overspeed alarm.
// - Encoder phase A, B or S open or shorted raises encoder disconnection.
// - Overload and regeneration overload warnings come before their alarm thresholds.
// - Parameter unit link errors at power-up and on timeout show on the unit only.
// - DC bus voltage too high or too low raises the voltage alarm.
`ifndef SAM_DEFINES_SVH
`define SAM_DEFINES_SVH

// ****************************************
// Alarm and warning codes
// ****************************************
`define SAM_C_PARAM 8'h04
`define SAM_C_OVERCUR 8'h10
`define SAM_C_REGEN_ERR 8'h30
`define SAM_C_REGEN_OVL 8'h32
`define SAM_C_VOLT 8'h40
`define SAM_C_OVERSPEED 8'h51
`define SAM_C_OVERLOAD 8'h70
`define SAM_C_DB_OVL 8'h73
`define SAM_C_INRUSH 8'h74
`define SAM_C_OVERHEAT 8'h7a
`define SAM_C_SYSTEM 8'hbf
`define SAM_C_RUNAWAY 8'hc1
`define SAM_C_PHASE 8'hc2
`define SAM_C_ENCODER 8'hc3
`define SAM_C_DEVIATION 8'hd0
`define SAM_C_WARN_OVL 8'h91
`define SAM_C_WARN_REGEN 8'h92
`define SAM_C_NONE 8'h00

// ****************************************
// Thresholds in percent
// ****************************************
`define SAM_OVL_ALARM_PCT 10'd120
`define SAM_OVL_WARN_PCT 10'd100
`define SAM_REGEN_ALARM_PCT 8'd100
`define SAM_REGEN_WARN_PCT 8'd85

// ****************************************
// Timing
// ****************************************
`define SAM_CLK_KHZ 50000
`define SAM_DISP_STEP_MS 500
`define SAM_PU_INIT_MS 100

// ****************************************
// Reset values
// ****************************************
`define SAM_RST_CODE 8'h00
`define SAM_RST_SEG 8'h00

`endif

// ### verilog/sam_pkg.sv
// Types shared by the servo alarm manager
package sam_pkg;
   typedef enum logic [1:0] {
      SAM_ST_NORMAL = 2'b00,
      SAM_ST_ALARM = 2'b01,
      SAM_ST_HARD = 2'b10
   } sam_state_e;
endpackage

// ### verilog/sam_detect.sv
// Monitor comparators and priority encoder for alarm and warning codes
`timescale 1ns/100ps
`include "sam_defines.svh"
module sam_detect #(
   parameter int PW = 24,
   parameter logic [15:0] MAX_SPEED = 16'd5000,
   parameter logic [11:0] DC_MIN = 12'd200,
   parameter logic [11:0] DC_MAX = 12'd400
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Monitors
   input wire logic [3:0] i_motor_type,
   input wire logic [3:0] i_cfg_motor_type,
   input wire logic [9:0] i_torque_pct,
   input wire logic [7:0] i_regen_pct,
   input wire logic [PW-1:0] i_resid_pulses,
   input wire logic [PW-1:0] i_overflow_level_setting,
   input wire logic i_cmd_dir,
   input wire logic i_meas_dir,
   input wire logic i_moving,
   input wire logic [15:0] i_speed,
   input wire logic [2:0] i_enc_open,
   input wire logic [2:0] i_enc_short,
   input wire logic [11:0] i_dc_volt,
   input wire logic i_overcurrent,
   input wire logic i_sys_error,
   input wire logic i_phase_error,
   input wire logic i_regen_error,
   input wire logic i_db_overload,
   input wire logic i_inrush_overload,
   input wire logic i_overheat,
   // Results
   output logic o_alarm,
   output logic [7:0] o_alarm_code,
   output logic o_warn,
   output logic [7:0] o_warn_code
);
   typedef struct packed {
      logic alarm;
      logic [7:0] code;
      logic warn;
      logic [7:0] wcode;
   } sam_det_s;

   sam_det_s s;
   sam_det_s next_s;

   // Power-cycle-only faults rank first so they are never masked by a soft one
   always_comb begin
      next_s = '0;
      next_s.alarm = 1'b1;
      if (i_motor_type != i_cfg_motor_type) begin
         next_s.code = `SAM_C_PARAM;
      end else if (i_overcurrent) begin
         next_s.code = `SAM_C_OVERCUR;
      end else if (i_sys_error) begin
         next_s.code = `SAM_C_SYSTEM;
      end else if (i_phase_error) begin
         next_s.code = `SAM_C_PHASE;
      end else if (|(i_enc_open | i_enc_short)) begin
         next_s.code = `SAM_C_ENCODER;
      end else if (i_dc_volt > DC_MAX || i_dc_volt < DC_MIN) begin
         next_s.code = `SAM_C_VOLT;
      end else if (i_regen_error) begin
         next_s.code = `SAM_C_REGEN_ERR;
      end else if (i_regen_pct > `SAM_REGEN_ALARM_PCT) begin
         next_s.code = `SAM_C_REGEN_OVL;
      end else if (i_speed > MAX_SPEED) begin
         next_s.code = `SAM_C_OVERSPEED;
      end else if (i_torque_pct > `SAM_OVL_ALARM_PCT) begin
         next_s.code = `SAM_C_OVERLOAD;
      end else if (i_db_overload) begin
         next_s.code = `SAM_C_DB_OVL;
      end else if (i_inrush_overload) begin
         next_s.code = `SAM_C_INRUSH;
      end else if (i_overheat) begin
         next_s.code = `SAM_C_OVERHEAT;
      end else if (i_moving && i_meas_dir != i_cmd_dir) begin
         next_s.code = `SAM_C_RUNAWAY;
      end else if (i_resid_pulses > i_overflow_level_setting) begin
         next_s.code = `SAM_C_DEVIATION;
      end else begin
         next_s.alarm = 1'b0;
      end
      next_s.warn = 1'b1;
      if (i_torque_pct > `SAM_OVL_WARN_PCT) begin
         next_s.wcode = `SAM_C_WARN_OVL;
      end else if (i_regen_pct > `SAM_REGEN_WARN_PCT) begin
         next_s.wcode = `SAM_C_WARN_REGEN;
      end else begin
         next_s.warn = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign o_alarm = s.alarm;
   assign o_alarm_code = s.code;
   assign o_warn = s.warn;
   assign o_warn_code = s.wcode;
endmodule // sam_detect

// ### verilog/sam_display.sv
// Front-panel sequencer: shows A, dot, high digit, low digit, blank in turn
`timescale 1ns/100ps
`include "sam_defines.svh"
module sam_display #(
   parameter int STEP_CYC = 25000000
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Code to show
   input wire logic i_show,
   input wire logic [7:0] i_code,
   // Segments, bit 7 is the dot
   output logic [7:0] o_seg
);
   typedef struct packed {
      logic [31:0] cnt;
      logic [2:0] idx;
      logic [7:0] seg;
   } sam_disp_s;

   sam_disp_s s;
   sam_disp_s next_s;

   function automatic logic [7:0] sam_hex_seg(input logic [3:0] d);
      logic [7:0] p;
      p = 8'h00;
      unique case (d)
         4'h0: p = 8'h3f;
         4'h1: p = 8'h06;
         4'h2: p = 8'h5b;
         4'h3: p = 8'h4f;
         4'h4: p = 8'h66;
         4'h5: p = 8'h6d;
         4'h6: p = 8'h7d;
         4'h7: p = 8'h07;
         4'h8: p = 8'h7f;
         4'h9: p = 8'h6f;
         4'ha: p = 8'h77;
         4'hb: p = 8'h7c;
         4'hc: p = 8'h39;
         4'hd: p = 8'h5e;
         4'he: p = 8'h79;
         4'hf: p = 8'h71;
      endcase
      return p;
   endfunction

   always_comb begin
      next_s = s;
      if (!i_show) begin
         next_s = '0;
      end else begin
         if (s.cnt == 32'(STEP_CYC - 1)) begin
            next_s.cnt = '0;
            next_s.idx = (s.idx == 3'h4) ? 3'h0 : s.idx + 3'h1;
         end else begin
            next_s.cnt = s.cnt + 32'h1;
         end
         case (next_s.idx)
            3'h0: next_s.seg = sam_hex_seg(4'ha);
            3'h1: next_s.seg = 8'h80;
            3'h2: next_s.seg = sam_hex_seg(i_code[7:4]);
            3'h3: next_s.seg = sam_hex_seg(i_code[3:0]);
            default: next_s.seg = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign o_seg = s.seg;
endmodule // sam_display

// ### testbench/sam_host_model.sv
// Host position controller and parameter unit model that drive the alarm manager's control pins
`timescale 1ns/100ps
module sam_host_model (
   // Clock
   input wire logic i_clk,
   // Host pins
   output logic o_run,
   output logic o_alarm_reset,
   // Parameter unit
   output logic o_key_reset,
   output logic o_pu_rx_ok,
   output logic o_pu_timeout
);
   // ****************************************
   // Pin drivers
   // ****************************************
   initial begin
      o_run = 1'b0;
      o_alarm_reset = 1'b0;
      o_key_reset = 1'b0;
      o_pu_rx_ok = 1'b0;
      o_pu_timeout = 1'b0;
   end

   task automatic set_run(input logic v);
      @(posedge i_clk);
      o_run <= v;
   endtask

   // Keep_run breaks the safe order on purpose, to show the restart hazard
   task automatic clear(input bit use_key, input bit keep_run);
      if (!keep_run) begin
         @(posedge i_clk);
         o_run <= 1'b0;
         repeat (5) @(posedge i_clk);
      end
      @(posedge i_clk);
      if (use_key) begin
         o_key_reset <= 1'b1;
      end else begin
         o_alarm_reset <= 1'b1;
      end
      // Held long enough for the pin synchroniser
      repeat (6) @(posedge i_clk);
      o_key_reset <= 1'b0;
      o_alarm_reset <= 1'b0;
   endtask

   task automatic pulse(input bit timeout);
      @(posedge i_clk);
      if (timeout) begin
         o_pu_timeout <= 1'b1;
      end else begin
         o_pu_rx_ok <= 1'b1;
      end
      @(posedge i_clk);
      o_pu_timeout <= 1'b0;
      o_pu_rx_ok <= 1'b0;
   endtask
endmodule // sam_host_model

// ### testbench/test_servo_alarm_manager.sv
// Self-checking testbench for the servo alarm manager
`timescale 1ns/100ps
module test_servo_alarm_manager;
   // ****************************************
   // Signals
   // ****************************************
   logic i_clk, i_srst, i_alarm_reset, i_run, i_key_reset, i_pu_rx_ok, i_pu_timeout;
   logic [3:0] i_motor_type = 4'h1, i_cfg_motor_type = 4'h1;
   logic [9:0] i_torque_pct = 10'd50;
   logic [7:0] i_regen_pct = 8'h0a;
   logic [23:0] i_resid_pulses = 24'h000100, i_overflow_level_setting = 24'h000100;
   logic i_cmd_dir = 1'b0, i_meas_dir = 1'b0, i_moving = 1'b0;
   logic [15:0] i_speed = 16'd5000;
   logic [2:0] i_enc_open = 3'h0, i_enc_short = 3'h0;
   logic [11:0] i_dc_volt = 12'd400;
   logic i_overcurrent = 0, i_sys_error = 0, i_phase_error = 0, i_regen_error = 0;
   logic i_db_overload = 0, i_inrush_overload = 0, i_overheat = 0;
   logic o_fault_output, o_power_enable, o_warning, o_pu_err_init, o_pu_err_timeout;
   logic [7:0] o_alarm_code, o_seg;
   int error_cnt = 0;
   int n_checks = 0;
   logic [7:0] codes [17] = '{8'h51, 8'h70, 8'h40, 8'h40, 8'hd0, 8'hc1, 8'h32, 8'h30,
      8'h73, 8'h74, 8'h7a, 8'h04, 8'h10, 8'hbf, 8'hc2, 8'hc3, 8'hc3};
   logic [7:0] seq [4] = '{8'h80, 8'h6d, 8'h06, 8'h00};

   sam_host_model host (.i_clk(i_clk), .o_run(i_run), .o_alarm_reset(i_alarm_reset),
      .o_key_reset(i_key_reset), .o_pu_rx_ok(i_pu_rx_ok), .o_pu_timeout(i_pu_timeout));

   // Short counts keep the display and link timers visible in a brief run
   sam_alarm_manager #(.DISP_STEP_CYC(4), .PU_INIT_CYC(8)) uut (.i_clk(i_clk),
      .i_srst(i_srst), .i_alarm_reset(i_alarm_reset), .i_run(i_run),
      .i_key_reset(i_key_reset), .i_pu_rx_ok(i_pu_rx_ok), .i_pu_timeout(i_pu_timeout),
      .i_motor_type(i_motor_type), .i_cfg_motor_type(i_cfg_motor_type),
      .i_torque_pct(i_torque_pct), .i_regen_pct(i_regen_pct), .i_resid_pulses(i_resid_pulses),
      .i_overflow_level_setting(i_overflow_level_setting), .i_cmd_dir(i_cmd_dir),
      .i_meas_dir(i_meas_dir),
      .i_moving(i_moving), .i_speed(i_speed), .i_enc_open(i_enc_open),
      .i_enc_short(i_enc_short), .i_dc_volt(i_dc_volt), .i_overcurrent(i_overcurrent),
      .i_sys_error(i_sys_error), .i_phase_error(i_phase_error),
      .i_regen_error(i_regen_error), .i_db_overload(i_db_overload),
      .i_inrush_overload(i_inrush_overload), .i_overheat(i_overheat),
      .o_fault_output(o_fault_output), .o_power_enable(o_power_enable),
      .o_alarm_code(o_alarm_code), .o_warning(o_warning), .o_seg(o_seg),
      .o_pu_err_init(o_pu_err_init), .o_pu_err_timeout(o_pu_err_timeout));

   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end

   // ****************************************
   // Helpers
   // ****************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wait_seg(input logic [7:0] v);
      for (int i = 0; i < 20 && o_seg !== v; i++) cyc(1);
   endtask

   // Speed, upper DC bus and residual pulse idle values sit exactly on the threshold; each on value is one step past its threshold
   task automatic set_mon(input int k, input bit on);
      @(posedge i_clk);
      case (k)
         0: i_speed <= on ? 16'd5001 : 16'd5000;
         1: i_torque_pct <= on ? 10'd121 : 10'd50;
         2: i_dc_volt <= on ? 12'd401 : 12'd400;
         3: i_dc_volt <= on ? 12'd199 : 12'd400;
         4: i_resid_pulses <= on ? 24'h000101 : 24'h000100;
         5: begin i_meas_dir <= on; i_moving <= on; end
         6: i_regen_pct <= on ? 8'd101 : 8'd10;
         7: i_regen_error <= on;
         8: i_db_overload <= on;
         9: i_inrush_overload <= on;
         10: i_overheat <= on;
         11: i_motor_type <= on ? 4'h2 : 4'h1;
         12: i_overcurrent <= on;
         13: i_sys_error <= on;
         14: i_phase_error <= on;
         15: i_enc_open <= {2'b00, on};
         default: i_enc_short <= {on, 2'b00};
      endcase
   endtask

   task automatic alarm_on(input int k);
      set_mon(k, 1'b1);
      cyc(3);
      chk("fault", 8'h01, o_fault_output);
      chk("power", 8'h00, o_power_enable);
      chk("code", codes[k], o_alarm_code);
      set_mon(k, 1'b0);
      cyc(3);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_link;
      cyc(12);
      chk("init err", 8'h01, o_pu_err_init);
      chk("seg link", 8'h00, o_seg);
      host.pulse(1'b0);
      cyc(2);
      chk("init err clr", 8'h00, o_pu_err_init);
      host.pulse(1'b1);
      cyc(2);
      chk("timeout err", 8'h01, o_pu_err_timeout);
      chk("seg timeout", 8'h00, o_seg);
      host.pulse(1'b0);
      cyc(2);
      chk("timeout clr", 8'h00, o_pu_err_timeout);
   endtask

   task automatic t_soft;
      for (int k = 0; k < 11; k++) begin
         host.set_run(1'b1);
         cyc(5);
         chk("power run", 8'h01, o_power_enable);
         alarm_on(k);
         host.clear(k[0], 1'b0);
         cyc(2);
         chk("fault clr", 8'h00, o_fault_output);
         chk("code clr", 8'h00, o_alarm_code);
         chk("power off", 8'h00, o_power_enable);
      end
   endtask

   task automatic t_hold_restart;
      host.set_run(1'b1);
      set_mon(1, 1'b1);
      set_mon(0, 1'b1);
      cyc(3);
      chk("code held", 8'h70, o_alarm_code);
      host.clear(1'b1, 1'b1);
      cyc(1);
      chk("fault held", 8'h01, o_fault_output);
      set_mon(0, 1'b0);
      set_mon(1, 1'b0);
      cyc(3);
      chk("code kept", 8'h70, o_alarm_code);
      host.clear(1'b1, 1'b1);
      cyc(1);
      chk("fault restart", 8'h00, o_fault_output);
      chk("power restart", 8'h01, o_power_enable);
   endtask

   task automatic t_display;
      set_mon(0, 1'b1);
      wait_seg(8'h77);
      chk("seg A", 8'h77, o_seg);
      for (int i = 0; i < 4; i++) begin
         cyc(4);
         chk("seg step", seq[i], o_seg);
      end
      set_mon(0, 1'b0);
      host.clear(1'b0, 1'b0);
      host.set_run(1'b1);
      cyc(5);
   endtask

   task automatic t_warn;
      @(posedge i_clk);
      i_torque_pct <= 10'd101;
      wait_seg(8'h77);
      chk("seg warn", 8'h77, o_seg);
      chk("warn ovl", 8'h01, o_warning);
      chk("power warn", 8'h01, o_power_enable);
      @(posedge i_clk);
      i_torque_pct <= 10'd120;
      cyc(3);
      chk("fault at 120", 8'h00, o_fault_output);
      @(posedge i_clk);
      i_torque_pct <= 10'd50;
      i_regen_pct <= 8'd86;
      cyc(3);
      chk("warn regen", 8'h01, o_warning);
      chk("fault regen", 8'h00, o_fault_output);
      @(posedge i_clk);
      i_regen_pct <= 8'd10;
      cyc(3);
      chk("warn gone", 8'h00, o_warning);
   endtask

   // Equal pairs stay quiet
   task automatic t_limits;
      @(posedge i_clk);
      i_cfg_motor_type <= 4'h2;
      i_motor_type <= 4'h2;
      {i_cmd_dir, i_meas_dir, i_moving} <= 3'h7;
      i_resid_pulses <= 24'h000101;
      i_overflow_level_setting <= 24'h000101;
      cyc(3);
      chk("quiet", 8'h00, o_fault_output);
      @(posedge i_clk);
      i_cfg_motor_type <= 4'h1;
      i_motor_type <= 4'h1;
      {i_cmd_dir, i_meas_dir, i_moving} <= 3'h0;
      i_resid_pulses <= 24'h000100;
      i_overflow_level_setting <= 24'h000100;
   endtask

   task automatic t_hard;
      for (int k = 11; k < 17; k++) begin
         alarm_on(k);
         host.clear(1'b0, 1'b0);
         host.clear(1'b1, 1'b0);
         cyc(2);
         chk("hard held", 8'h01, o_fault_output);
         chk("hard code", codes[k], o_alarm_code);
         @(posedge i_clk);
         i_srst <= 1'b1;
         cyc(2);
         @(posedge i_clk);
         i_srst <= 1'b0;
         cyc(1);
         chk("cycle clr", 8'h00, o_fault_output);
         chk("cycle code", 8'h00, o_alarm_code);
      end
   endtask

   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      i_srst = 1'b1;
      repeat (4) @(posedge i_clk);
      i_srst <= 1'b0;
      cyc(1);
      chk("fault rst", 8'h00, o_fault_output);
      chk("seg rst", 8'h00, o_seg);
      t_link();
      t_soft();
      t_hold_restart();
      t_display();
      t_warn();
      t_limits();
      t_hard();
      print_verdict();
   end

   // The whole sequence needs well under a thousand cycles
   initial begin
      #100000;
      error_cnt++;
      print_verdict();
   end
endmodule // test_servo_alarm_manager
